// ---- core/flc_fan_loop.sv ----
// Fan drive controller with second loop configuration register and register port
// How it works
// - Loop off and ramp off: a written drive value reaches the PWM immediately.
// - Ramp on and loop off: PWM moves toward drive value, at most fan step per update.
// - Derivative option field sits at bits 4:3, resets to 11, loop only.
// - Option 00: no derivative term, change capped at fan step.
// - Option 01: derivative added to P and I terms, change capped at fan step.
// - Option 10: derivative added, fan step cap ignored.
// - Option 11: derivative counted twice, fan step cap ignored.
// - Loop on and speed inside error window: drive setting held.
// - Update period codes 000..111: 100..1600 ms, reset 400 ms.
// - Loop enable resets clear; when set drive is adjusted toward target speed.
// - Fan step is the largest capped drive change per update.
//
// Our own choice: strobed register access.
module flc_fan_loop
    import flc_pkg::*;
#(
    parameter int MS_COUNT = MS_CYCLES
) (
    input  wire  logic        CLK,
    input  wire  logic        RST,
    input  wire  logic [7:0]  ADDR,
    input  wire  logic [7:0]  WDATA,
    input  wire  logic        WR,
    input  wire  logic        RD,
    output logic       [7:0]  RDATA,
    input  wire  logic [15:0] TARGET_RPM,
    input  wire  logic [15:0] MEASURED_RPM,
    output logic       [7:0]  PWM_DRIVE,
    output logic              PWM_OUT
);

    // ************************************************************
    // Register port
    // ************************************************************
    flc_bus_t   bus;
    logic [7:0] drive_setting;
    logic [7:0] cfg_one;
    logic [7:0] cfg_two;
    logic [7:0] fan_step;

    assign bus = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};

    always_ff @(posedge CLK) begin
        if (RST) begin
            drive_setting <= RST_DRIVE;
            cfg_one       <= RST_CFG_ONE;
            cfg_two       <= RST_CFG_TWO;
            fan_step      <= RST_FAN_STEP;
        end else if (bus.wr) begin
            case (bus.addr)
                OFS_DRIVE:    drive_setting <= bus.wdata;
                OFS_CFG_ONE:  cfg_one       <= bus.wdata;
                OFS_CFG_TWO:  cfg_two       <= bus.wdata;
                OFS_FAN_STEP: fan_step      <= bus.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            RDATA <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                OFS_DRIVE:    RDATA <= drive_setting;
                OFS_PWM_NOW:  RDATA <= PWM_DRIVE;
                OFS_CFG_ONE:  RDATA <= cfg_one;
                OFS_CFG_TWO:  RDATA <= cfg_two;
                OFS_FAN_STEP: RDATA <= fan_step;
                default:      RDATA <= 8'h00;
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end

    // ************************************************************
    // Field decode
    // ************************************************************
    logic       closed_loop_enable;
    logic       manual_ramp_enable;
    logic [1:0] derivative_option;
    logic [1:0] error_window_select;
    logic [2:0] update_select;
    flc_mode_t  mode;

    assign closed_loop_enable  = cfg_one[LOOP_EN_BIT];
    assign update_select       = cfg_one[UPD_LSB +: 3];
    assign manual_ramp_enable  = cfg_two[RAMP_EN_BIT];
    assign derivative_option   = cfg_two[DER_LSB +: 2];
    assign error_window_select = cfg_two[WIN_LSB +: 2];

    always_comb begin
        if (closed_loop_enable) begin
            mode = MODE_LOOP;
        end else if (manual_ramp_enable) begin
            mode = MODE_RAMP;
        end else begin
            mode = MODE_DIRECT;
        end
    end

    // ************************************************************
    // Update period timer
    // ************************************************************
    logic [$clog2(MS_COUNT)-1:0] cyc_count;
    logic                        ms_tick;
    logic [10:0]                 ms_count;
    logic                        update_tick;

    always_ff @(posedge CLK) begin
        if (RST) begin
            cyc_count <= '0;
            ms_tick   <= 1'b0;
        end else if (cyc_count == ($clog2(MS_COUNT))'(MS_COUNT - 1)) begin
            cyc_count <= '0;
            ms_tick   <= 1'b1;
        end else begin
            cyc_count <= cyc_count + ($clog2(MS_COUNT))'(1);
            ms_tick   <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ms_count    <= 11'd0;
            update_tick <= 1'b0;
        end else if (ms_tick && ms_count >= flc_update_ms(update_select) - 11'd1) begin
            ms_count    <= 11'd0;
            update_tick <= 1'b1;
        end else begin
            ms_count    <= ms_tick ? ms_count + 11'd1 : ms_count;
            update_tick <= 1'b0;
        end
    end

    // ************************************************************
    // Closed loop terms
    // ************************************************************
    logic signed [19:0] err;
    logic signed [19:0] prev_err;
    logic signed [19:0] integ;
    logic signed [19:0] d_raw;
    logic signed [19:0] d_term;
    logic signed [19:0] delta;
    logic signed [19:0] step_s;
    logic signed [19:0] loop_sum;
    logic        [19:0] abs_err;
    logic               in_window;
    logic        [7:0]  next_loop;

    assign err       = 20'(signed'({4'h0, TARGET_RPM})) - 20'(signed'({4'h0, MEASURED_RPM}));
    assign abs_err   = err[19] ? 20'(-err) : 20'(err);
    assign in_window = abs_err <= {4'h0, flc_window_rpm(error_window_select)};
    assign d_raw     = (err - prev_err) >>> D_SHIFT;
    assign step_s    = signed'({12'h000, fan_step});

    always_comb begin
        case (derivative_option)
            2'b00:   d_term = '0;
            2'b01:   d_term = d_raw;
            2'b10:   d_term = d_raw;
            2'b11:   d_term = d_raw <<< 1;
            default: d_term = '0;
        endcase
        delta = (err >>> P_SHIFT) + integ + d_term;
        if (!derivative_option[1]) begin
            if (delta > step_s) begin
                delta = step_s;
            end else if (delta < -step_s) begin
                delta = -step_s;
            end
        end
        loop_sum = signed'({12'h000, PWM_DRIVE}) + delta;
        if (loop_sum < 0) begin
            next_loop = 8'h00;
        end else if (loop_sum > signed'({12'h000, DRIVE_MAX})) begin
            next_loop = DRIVE_MAX;
        end else begin
            next_loop = loop_sum[7:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            prev_err <= '0;
            integ    <= '0;
        end else if (mode != MODE_LOOP) begin
            prev_err <= '0;
            integ    <= '0;
        end else if (update_tick && !in_window) begin
            prev_err <= err;
            integ    <= integ + (err >>> I_SHIFT);
        end
    end

    // ************************************************************
    // Drive update
    // ************************************************************
    logic [7:0] next_ramp;
    logic [7:0] gap;

    assign gap = flc_absdiff(drive_setting, PWM_DRIVE);

    always_comb begin
        if (gap <= fan_step) begin
            next_ramp = drive_setting;
        end else if (drive_setting > PWM_DRIVE) begin
            next_ramp = PWM_DRIVE + fan_step;
        end else begin
            next_ramp = PWM_DRIVE - fan_step;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            PWM_DRIVE <= RST_DRIVE;
        end else begin
            case (mode)
                MODE_DIRECT: begin
                    if (bus.wr && bus.addr == OFS_DRIVE) begin
                        PWM_DRIVE <= bus.wdata;
                    end else begin
                        PWM_DRIVE <= drive_setting;
                    end
                end
                MODE_RAMP: begin
                    if (update_tick) begin
                        PWM_DRIVE <= next_ramp;
                    end
                end
                MODE_LOOP: begin
                    if (update_tick && !in_window) begin
                        PWM_DRIVE <= next_loop;
                    end
                end
                default: PWM_DRIVE <= drive_setting;
            endcase
        end
    end

    // ************************************************************
    // PWM waveform
    // ************************************************************
    logic [7:0] pwm_phase;

    always_ff @(posedge CLK) begin
        if (RST) begin
            pwm_phase <= 8'h00;
            PWM_OUT   <= 1'b0;
        end else begin
            pwm_phase <= pwm_phase + 8'h01;
            PWM_OUT   <= (PWM_DRIVE == DRIVE_MAX) || (pwm_phase < PWM_DRIVE);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    instant_apply_a: assert property (@(posedge CLK) disable iff (RST)
        (mode == MODE_DIRECT && bus.wr && bus.addr == OFS_DRIVE) |=> PWM_DRIVE == $past(WDATA))
        else $error("drive write not applied at once");

    ramp_step_a: assert property (@(posedge CLK) disable iff (RST)
        (mode == MODE_RAMP) |=> flc_absdiff(PWM_DRIVE, $past(PWM_DRIVE)) <= $past(fan_step))
        else $error("ramp step larger than fan step");

    ramp_quiet_a: assert property (@(posedge CLK) disable iff (RST)
        (mode == MODE_RAMP && !update_tick) |=> PWM_DRIVE == $past(PWM_DRIVE))
        else $error("ramp moved between updates");

    no_overshoot_a: assert property (@(posedge CLK) disable iff (RST)
        (mode == MODE_RAMP && update_tick && gap <= fan_step) |=> PWM_DRIVE == $past(drive_setting))
        else $error("ramp missed its end value");

    der_reset_a: assert property (@(posedge CLK)
        RST |=> derivative_option == RST_DERIVATIVE_OPTION && !closed_loop_enable)
        else $error("wrong reset of loop fields");

    cfg_reset_a: assert property (@(posedge CLK)
        RST |=> cfg_two == RST_CFG_TWO && update_select == RST_CFG_ONE[UPD_LSB +: 3])
        else $error("wrong reset of config fields");

    direct_follow_a: assert property (@(posedge CLK) disable iff (RST)
        (mode == MODE_DIRECT && !bus.wr) |=> PWM_DRIVE == $past(drive_setting))
        else $error("drive not following setting");

    ramp_full_step_a: assert property (@(posedge CLK) disable iff (RST)
        (mode == MODE_RAMP && update_tick && gap > fan_step)
        |=> flc_absdiff(PWM_DRIVE, $past(PWM_DRIVE)) == $past(fan_step))
        else $error("ramp step not a full fan step");

    capped_a: assert property (@(posedge CLK) disable iff (RST)
        (mode == MODE_LOOP && update_tick && !derivative_option[1] && $stable(fan_step))
        |=> flc_absdiff(PWM_DRIVE, $past(PWM_DRIVE)) <= $past(fan_step))
        else $error("loop step over fan step");

    window_hold_a: assert property (@(posedge CLK) disable iff (RST)
        (mode == MODE_LOOP && in_window) |=> PWM_DRIVE == $past(PWM_DRIVE))
        else $error("drive changed inside window");

    update_period_a: assert property (@(posedge CLK) disable iff (RST)
        update_tick |-> ms_count == 11'd0 && $past(ms_tick))
        else $error("update tick off its period");

endmodule : flc_fan_loop

// ---- core/flc_pkg.sv ----
// Constants, types and decode functions for the fan loop configuration block
package flc_pkg;

    // ************************************************************
    // Register offsets and reset values
    // ************************************************************
    localparam logic [7:0] OFS_DRIVE     = 8'h00;
    localparam logic [7:0] OFS_PWM_NOW   = 8'h01;
    localparam logic [7:0] OFS_CFG_ONE   = 8'h02;
    localparam logic [7:0] OFS_CFG_TWO   = 8'h03;
    localparam logic [7:0] OFS_FAN_STEP  = 8'h04;

    localparam logic [7:0] RST_DRIVE     = 8'h00;
    localparam logic [7:0] RST_CFG_ONE   = 8'h03;
    localparam logic [7:0] RST_CFG_TWO   = 8'h1A;
    localparam logic [7:0] RST_FAN_STEP  = 8'h10;
    localparam logic [1:0] RST_DERIVATIVE_OPTION   = 2'h3;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int LOOP_EN_BIT   = 7;
    localparam int UPD_LSB       = 0;
    localparam int RAMP_EN_BIT   = 6;
    localparam int DER_LSB       = 3;
    localparam int WIN_LSB       = 1;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

    // ************************************************************
    // Loop term scaling
    // ************************************************************
    localparam int P_SHIFT       = 4;
    localparam int I_SHIFT       = 6;
    localparam int D_SHIFT       = 4;
    localparam logic [7:0] DRIVE_MAX = 8'hFF;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        MODE_DIRECT = 2'b00,
        MODE_RAMP   = 2'b01,
        MODE_LOOP   = 2'b10
    } flc_mode_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } flc_bus_t;

    // ************************************************************
    // Decoders
    // ************************************************************
    function automatic logic [10:0] flc_update_ms(input logic [2:0] sel);
        case (sel)
            3'h0:    flc_update_ms = 11'd100;
            3'h1:    flc_update_ms = 11'd200;
            3'h2:    flc_update_ms = 11'd300;
            3'h3:    flc_update_ms = 11'd400;
            3'h4:    flc_update_ms = 11'd500;
            3'h5:    flc_update_ms = 11'd800;
            3'h6:    flc_update_ms = 11'd1200;
            default: flc_update_ms = 11'd1600;
        endcase
    endfunction : flc_update_ms

    function automatic logic [15:0] flc_window_rpm(input logic [1:0] sel);
        case (sel)
            2'h0:    flc_window_rpm = 16'd0;
            2'h1:    flc_window_rpm = 16'd50;
            2'h2:    flc_window_rpm = 16'd100;
            default: flc_window_rpm = 16'd200;
        endcase
    endfunction : flc_window_rpm

    function automatic logic [7:0] flc_absdiff(input logic [7:0] a, input logic [7:0] b);
        flc_absdiff = (a > b) ? a - b : b - a;
    endfunction : flc_absdiff

endpackage : flc_pkg

// ---- testbench/flc_fan_model.sv ----
// Fan model: measured speed follows the PWM drive one cycle later
module flc_fan_model
    import flc_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic [7:0]  PWM_DRIVE,
    output logic      [15:0] MEASURED_RPM
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // Speed is sixteen RPM per drive step
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (RST) begin
            MEASURED_RPM <= 16'h0000;
        end else begin
            MEASURED_RPM <= {4'h0, PWM_DRIVE, 4'h0};
        end
    end
endmodule : flc_fan_model

// ---- testbench/flc_fan_loop_bench.sv ----
// Self-checking bench for the fan loop configuration block
module flc_fan_loop_bench
    import flc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  rdata;
    logic [15:0] target = 16'h0000;
    logic [15:0] meas;
    logic [7:0]  pwm;
    logic        pwm_out;
    int          n_fail = 0;
    int          num_checks = 0;
    int          seed = 81;
    always #10 clk = ~clk;
    flc_fan_loop #(.MS_COUNT(10)) u_dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .TARGET_RPM(target), .MEASURED_RPM(meas), .PWM_DRIVE(pwm), .PWM_OUT(pwm_out));
    flc_fan_model u_fan (.CLK(clk), .RST(rst), .PWM_DRIVE(pwm), .MEASURED_RPM(meas));
    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [15:0] win_rpm(input int w);
        case (w)
            0:       win_rpm = 16'd0;
            1:       win_rpm = 16'd50;
            2:       win_rpm = 16'd100;
            default: win_rpm = 16'd200;
        endcase
    endfunction : win_rpm
    function automatic int duty_exp(input logic [7:0] duty);
        duty_exp = (duty == 8'hFF) ? 256 : int'(duty);
    endfunction : duty_exp
    task automatic test_done();
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chkb(input string what, input logic cond);
        num_checks++;
        if (cond !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED %s expected 1 seen %b", what, cond);
        end
    endtask : chkb
    task automatic chk_duty(input logic [7:0] duty);
        int hi;
        int lo;
        hi = 0;
        lo = 0;
        repeat (256) begin
            @(posedge clk);
            #1;
            if (pwm_out === 1'b1) hi++;
            if (pwm_out === 1'b0) lo++;
        end
        num_checks++;
        if (hi != duty_exp(duty) || lo != 256 - duty_exp(duty)) begin
            n_fail++;
            $display("CHECK FAILED pwm duty expected %0d seen %0d", duty_exp(duty), hi);
        end
    endtask : chk_duty
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg
    task automatic wait_change(input int lim, output int cyc);
        logic [7:0] prev;
        prev = pwm;
        cyc = 0;
        while (pwm === prev && cyc < lim) begin
            @(posedge clk);
            #1;
            cyc++;
        end
    endtask : wait_change
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [7:0] d;
        logic [7:0] old;
        logic [7:0] exp;
        int         cyc;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // Reset values and unmapped read
        rd_reg(OFS_DRIVE, d);
        chk("drive reset", RST_DRIVE, d);
        rd_reg(OFS_CFG_ONE, d);
        chk("cfg one reset", RST_CFG_ONE, d);
        rd_reg(OFS_CFG_TWO, d);
        chk("cfg two reset", 8'h1A, d);
        rd_reg(OFS_FAN_STEP, d);
        chk("fan step reset", RST_FAN_STEP, d);
        wr_reg(8'h07, 8'h5A);
        rd_reg(8'h07, d);
        chk("unmapped read", 8'h00, d);
        // Random direct writes and readback
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            wr_reg(OFS_CFG_TWO, d & 8'hBF);
            rd_reg(OFS_CFG_TWO, old);
            chk("cfg two rw", d & 8'hBF, old);
            wr_reg(OFS_DRIVE, ~d);
            chk("direct drive", ~d, pwm);
            chk_duty(~d);
            rd_reg(OFS_PWM_NOW, old);
            chk("pwm readback", ~d, old);
        end
        // Ramp with update code 0
        wr_reg(OFS_CFG_TWO, 8'h1A);
        wr_reg(OFS_DRIVE, 8'h00);
        wr_reg(OFS_CFG_ONE, 8'h00);
        wr_reg(OFS_FAN_STEP, 8'h10);
        wr_reg(OFS_CFG_TWO, 8'h5A);
        wr_reg(OFS_DRIVE, 8'd100);
        chk("ramp no jump", 8'h00, pwm);
        for (int s = 0; s < 7; s++) begin
            old = pwm;
            wait_change(1100, cyc);
            exp = (8'd100 - old > 8'h10) ? old + 8'h10 : 8'd100;
            chk("ramp step", exp, pwm);
            if (s > 0) chkb("update period", cyc == 1000);
        end
        wait_change(1100, cyc);
        chk("ramp end", 8'd100, pwm);
        // Error window hold and release
        for (int w = 0; w < 4; w++) begin
            wr_reg(OFS_CFG_ONE, 8'h00);
            wr_reg(OFS_CFG_TWO, 8'h18 | (w << 1));
            wr_reg(OFS_DRIVE, 8'h40);
            @(posedge clk);
            target <= 16'd1024 + win_rpm(w);
            wr_reg(OFS_CFG_ONE, 8'h80);
            wait_change(2100, cyc);
            chk("window hold", 8'h40, pwm);
            @(posedge clk);
            target <= 16'd1049 + win_rpm(w);
            wait_change(2100, cyc);
            chkb("window leave", pwm !== 8'h40);
        end
        // Derivative options and fan step cap
        for (int o = 0; o < 4; o++) begin
            wr_reg(OFS_CFG_ONE, 8'h00);
            wr_reg(OFS_CFG_TWO, (o << 3) | 8'h02);
            wr_reg(OFS_FAN_STEP, 8'h04);
            wr_reg(OFS_DRIVE, 8'h10);
            @(posedge clk);
            target <= 16'd4000;
            wr_reg(OFS_CFG_ONE, 8'h80);
            wait_change(1100, cyc);
            if (o < 2) chkb("capped step", pwm > 8'h10 && pwm <= 8'h14);
            else chkb("uncapped step", pwm > 8'h14);
        end
        test_done();
    end
    // ************************************************************
    // Watchdog
    // ************************************************************
    initial begin
        #(60000 * 20);
        n_fail++;
        test_done();
    end
endmodule : flc_fan_loop_bench
